// [logic/lcvc_params.svh]
// constants for the line code violation counter bank
// Summary of operation
// - each channel counter is 16 bits; reaching full scale raises channel overflow.
// - a full counter holds ffff without wrapping until a counter reset.
// - monitor source select bit 7 picks violation activity (0) or overflow (1).
// - by default the per-channel monitor status shows violation activity.
// - readback byte shows counts only while readback enable bit 6 is set.
// - channel select 0 means none; codes 1 to 14 select channels 0 to 13.
// - the same channel select steers per-channel latch and per-channel reset.
// - reset-every-counter bit clears all counters while set; hold it 1 us.
// - latch-every-counter bit copies all 14 counters into holding registers.
// - readback half select 0 gives the low byte, 1 the high byte.
// - latch-selected bit copies only the selected counter into its holding register.
// - control bit 0 clears only the selected counter; hold it 1 us.
// - read-only readback byte shows the chosen half of the selected held count.
`ifndef LCVC_PARAMS_SVH
`define LCVC_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define LCVC_ADDR_CHAN_SELECT 8'he5
`define LCVC_ADDR_CONTROL 8'he6
`define LCVC_ADDR_READBACK 8'he8
`define LCVC_REG_RESET 8'h00
`define LCVC_READ_ZERO 8'h00

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define LCVC_SEL_MON_SRC 7
`define LCVC_SEL_RD_EN 6
`define LCVC_SEL_CH_HI 3
`define LCVC_SEL_CH_LO 0
`define LCVC_CH_NONE 4'h0
`define LCVC_CH_FIRST 4'h1
`define LCVC_CTRL_RST_ALL 4
`define LCVC_CTRL_LATCH_ALL 3
`define LCVC_CTRL_HALF 2
`define LCVC_CTRL_LATCH_SEL 1
`define LCVC_CTRL_RST_SEL 0

// ----------------------------------------------------------------
// counters and timing
// ----------------------------------------------------------------
`define LCVC_CHANNELS 14
`define LCVC_CNT_W 16
`define LCVC_CNT_FULL 16'hffff
`define LCVC_CNT_ZERO 16'h0000
`define LCVC_CNT_ONE 16'h0001
`define LCVC_CLK_PERIOD_NS 10
`define LCVC_RST_HOLD_NS 1000
`define LCVC_RST_HOLD_CYC ((`LCVC_RST_HOLD_NS + `LCVC_CLK_PERIOD_NS - 1) / `LCVC_CLK_PERIOD_NS)

`endif

// [logic/lcvc_pkg.sv]
// types for the line code violation counter bank
`include "lcvc_params.svh"

package lcvc_pkg;

  typedef logic [7:0] lcvc_byte_t;
  typedef logic [`LCVC_CNT_W-1:0] lcvc_count_t;
  typedef logic [`LCVC_CHANNELS-1:0] lcvc_chvec_t;
  typedef lcvc_count_t [`LCVC_CHANNELS-1:0] lcvc_count_arr_t;

  // whole state of the bank top
  typedef struct packed {
    lcvc_byte_t chan_select;
    lcvc_byte_t control;
    lcvc_count_arr_t hold;
    lcvc_byte_t rdata;
    lcvc_chvec_t monitor;
  } lcvc_state_t;

  // whole state of one channel counter
  typedef struct packed {
    lcvc_count_t count;
  } lcvc_cnt_state_t;

endpackage : lcvc_pkg

// [logic/lcvc_counter.sv]
// one saturating line code violation counter
`timescale 1ns/1ps
`include "lcvc_params.svh"

module lcvc_counter (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // control
  input wire logic clear_in,
  input wire logic pulse_in,
  // status
  output lcvc_pkg::lcvc_count_t count_out,
  output logic full_out
);
  import lcvc_pkg::*;

  lcvc_cnt_state_t s_q;
  lcvc_cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear_in) begin
      s_d.count = `LCVC_CNT_ZERO;
    end else if (pulse_in && (s_q.count != `LCVC_CNT_FULL)) begin
      s_d.count = s_q.count + `LCVC_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_out = s_q.count;
  assign full_out = (s_q.count == `LCVC_CNT_FULL);

  a_sat_stays_full: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (full_out && !clear_in) |=> full_out)
    else $error("saturated counter left full scale without a clear");

  a_count_step_one: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (pulse_in && !clear_in && !full_out) |=> (count_out == $past(count_out) + `LCVC_CNT_ONE))
    else $error("counter did not advance by one on a violation");

  a_count_idle_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (!pulse_in && !clear_in) |=> $stable(count_out))
    else $error("counter moved without a violation");

  a_clear_to_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    clear_in |=> (count_out == `LCVC_CNT_ZERO))
    else $error("cleared counter is not zero");

endmodule : lcvc_counter

// [logic/lcvc_bank.sv]
// line code violation counter bank with its control registers
`timescale 1ns/1ps
`include "lcvc_params.svh"

module lcvc_bank #(
  parameter int CHANNELS = `LCVC_CHANNELS
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire lcvc_pkg::lcvc_byte_t reg_addr_in,
  input wire lcvc_pkg::lcvc_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output lcvc_pkg::lcvc_byte_t reg_rdata_out,
  // violation pulses from the line decoders
  input wire lcvc_pkg::lcvc_chvec_t lcv_pulse_in,
  // per-channel status
  output lcvc_pkg::lcvc_chvec_t monitor_status_out,
  output lcvc_pkg::lcvc_chvec_t overflow_out
);
  import lcvc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic chan_valid(input lcvc_byte_t sel);
    logic [3:0] code;
    code = sel[`LCVC_SEL_CH_HI:`LCVC_SEL_CH_LO];
    chan_valid = (code != `LCVC_CH_NONE) && (code <= 4'(CHANNELS));
  endfunction : chan_valid

  function automatic logic [3:0] chan_index(input lcvc_byte_t sel);
    chan_index = sel[`LCVC_SEL_CH_HI:`LCVC_SEL_CH_LO] - `LCVC_CH_FIRST;
  endfunction : chan_index

  function automatic lcvc_byte_t pick_half(input lcvc_count_t value, input logic high);
    pick_half = high ? value[15:8] : value[7:0];
  endfunction : pick_half

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lcvc_state_t s_q;
  lcvc_state_t s_d;
  lcvc_count_arr_t counts;
  lcvc_chvec_t full;
  lcvc_chvec_t clear;
  logic sel_valid;
  logic [3:0] sel_index;
  lcvc_byte_t readback_value;

  assign sel_valid = chan_valid(s_q.chan_select);
  assign sel_index = chan_index(s_q.chan_select);

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // clears act for as long as the control bit stays set, so a long hold is harmless
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      clear[i] = s_q.control[`LCVC_CTRL_RST_ALL]
        || (s_q.control[`LCVC_CTRL_RST_SEL] && sel_valid && (sel_index == 4'(i)));
    end
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    lcvc_counter lcvc_counter_i (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(clear[g]),
      .pulse_in(lcv_pulse_in[g]),
      .count_out(counts[g]),
      .full_out(full[g])
    );
  end

  // ----------------------------------------------------------------
  // readback selection
  // ----------------------------------------------------------------
  always_comb begin
    readback_value = `LCVC_READ_ZERO;
    if (s_q.chan_select[`LCVC_SEL_RD_EN] && sel_valid) begin
      readback_value = pick_half(s_q.hold[sel_index], s_q.control[`LCVC_CTRL_HALF]);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = `LCVC_READ_ZERO;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `LCVC_ADDR_CHAN_SELECT: s_d.chan_select = reg_wdata_in;
        `LCVC_ADDR_CONTROL: s_d.control = reg_wdata_in;
        default: s_d.rdata = `LCVC_READ_ZERO;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `LCVC_ADDR_CHAN_SELECT: s_d.rdata = s_q.chan_select;
        `LCVC_ADDR_CONTROL: s_d.rdata = s_q.control;
        `LCVC_ADDR_READBACK: s_d.rdata = readback_value;
        default: s_d.rdata = `LCVC_READ_ZERO;
      endcase
    end
    // holding registers track while the latch bit is set; the last copy sticks on clear
    for (int i = 0; i < CHANNELS; i++) begin
      if (s_q.control[`LCVC_CTRL_LATCH_ALL]) begin
        s_d.hold[i] = counts[i];
      end else if (s_q.control[`LCVC_CTRL_LATCH_SEL] && sel_valid && (sel_index == 4'(i))) begin
        s_d.hold[i] = counts[i];
      end
    end
    for (int i = 0; i < CHANNELS; i++) begin
      s_d.monitor[i] = s_q.chan_select[`LCVC_SEL_MON_SRC] ? full[i] : lcv_pulse_in[i];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out = s_q.rdata;
  assign monitor_status_out = s_q.monitor;
  assign overflow_out = full;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_overflow_at_full: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (!clear[0] && lcv_pulse_in[0] && counts[0] == (`LCVC_CNT_FULL - `LCVC_CNT_ONE)) |=> overflow_out[0])
    else $error("overflow not raised when counter reached full scale");

  a_monitor_source: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    1'b1 |=> (monitor_status_out ==
      ($past(s_q.chan_select[`LCVC_SEL_MON_SRC]) ? $past(full) : $past(lcv_pulse_in))))
    else $error("monitor status shows the wrong source");

  a_monitor_default: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (!s_q.chan_select[`LCVC_SEL_MON_SRC] && lcv_pulse_in[0]) |=> monitor_status_out[0])
    else $error("violation activity missing from monitor status");

  a_readback_gated: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (reg_rd_in && reg_addr_in == `LCVC_ADDR_READBACK && !s_q.chan_select[`LCVC_SEL_RD_EN])
      |=> (reg_rdata_out == `LCVC_READ_ZERO))
    else $error("readback byte visible while readback disabled");

  a_no_channel_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (reg_rd_in && reg_addr_in == `LCVC_ADDR_READBACK
      && s_q.chan_select[`LCVC_SEL_CH_HI:`LCVC_SEL_CH_LO] == `LCVC_CH_NONE)
      |=> (reg_rdata_out == `LCVC_READ_ZERO))
    else $error("readback not zero with no channel selected");

  a_readback_half: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (reg_rd_in && reg_addr_in == `LCVC_ADDR_READBACK && s_q.chan_select[`LCVC_SEL_RD_EN] && sel_valid)
      |=> (reg_rdata_out == ($past(s_q.control[`LCVC_CTRL_HALF]) ?
        $past(s_q.hold[sel_index][15:8]) : $past(s_q.hold[sel_index][7:0]))))
    else $error("readback byte does not match selected held half");

  a_rdata_one_cycle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !reg_rd_in |=> (reg_rdata_out == `LCVC_READ_ZERO))
    else $error("read data stood outside its cycle");

  a_latch_every: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_q.control[`LCVC_CTRL_LATCH_ALL] |=> (s_q.hold == $past(counts)))
    else $error("latch of every counter missed a channel");

  a_latch_selected: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (s_q.control[`LCVC_CTRL_LATCH_SEL] && !s_q.control[`LCVC_CTRL_LATCH_ALL] && sel_valid)
      |=> (s_q.hold[$past(sel_index)] == $past(counts[sel_index])))
    else $error("selected holding register not latched");

  a_latch_none_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (!s_q.control[`LCVC_CTRL_LATCH_ALL] && !sel_valid) |=> $stable(s_q.hold))
    else $error("holding registers changed with no channel selected");

  a_reset_every: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    s_q.control[`LCVC_CTRL_RST_ALL] |=> (counts == '0))
    else $error("reset of every counter left a nonzero count");

  a_reset_selected: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (s_q.control[`LCVC_CTRL_RST_SEL] && sel_valid) |=> (counts[$past(sel_index)] == `LCVC_CNT_ZERO))
    else $error("selected counter not cleared");

endmodule : lcvc_bank

// [testbench/lcvc_bank_tb.sv]
// self-checking bench for the violation counter bank
`timescale 1ns/1ps

module lcvc_bank_tb;
  import lcvc_pkg::*;

  logic sys_clk_in;
  logic sys_rst_in;
  lcvc_byte_t reg_addr_in;
  lcvc_byte_t reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  lcvc_byte_t reg_rdata_out;
  lcvc_chvec_t lcv_pulse_in;
  lcvc_chvec_t monitor_status_out;
  lcvc_chvec_t overflow_out;
  lcvc_byte_t exp_q[$];
  logic rd_pend = 1'b0;
  logic mon = 1'b0;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'h10c2;
  int cnt[14];
  lcvc_chvec_t cur;
  lcvc_chvec_t prev;

  lcvc_bank #(.CHANNELS(14)) lcvc_bank_i (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .lcv_pulse_in(lcv_pulse_in), .monitor_status_out(monitor_status_out),
    .overflow_out(overflow_out)
  );

  // ----------------------------------------------------------------
  // clock, timeout, report
  // ----------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ceiling covers the 65539-cycle saturation run plus register traffic
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // compares
  // ----------------------------------------------------------------
  task automatic cmp_byte(input string name, input lcvc_byte_t e, input lcvc_byte_t g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_vec(input string name, input lcvc_chvec_t e, input lcvc_chvec_t g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask : cmp_vec

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk_in) begin
    if (rd_pend === 1'b1) begin
      cmp_byte("read data", exp_q.pop_front(), reg_rdata_out);
    end
    rd_pend <= reg_rd_in;
  end

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wr(input lcvc_byte_t a, input lcvc_byte_t d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input lcvc_byte_t a, input lcvc_byte_t e);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    exp_q.push_back(e);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
  endtask : rd

  // control bits act while set, so hold them and then drop them
  task automatic ctl(input lcvc_byte_t d, input int n);
    wr(8'he6, d);
    repeat (n) @(posedge sys_clk_in);
    wr(8'he6, 8'h00);
  endtask : ctl

  task automatic rd_chan(input logic [3:0] code, input logic en, input lcvc_count_t e);
    lcvc_count_t v;
    v = (en && code != 4'h0 && code != 4'hf) ? e : 16'h0000;
    wr(8'he5, {mon, en, 2'b00, code});
    wr(8'he6, 8'h00);
    rd(8'he8, v[7:0]);
    wr(8'he6, 8'h04);
    rd(8'he8, v[15:8]);
  endtask : rd_chan

  task automatic pulse(input lcvc_chvec_t m, input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      lcv_pulse_in <= m;
    end
    @(posedge sys_clk_in);
    lcv_pulse_in <= 14'h0000;
    for (int i = 0; i < 14; i++) if (m[i]) cnt[i] += n;
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    lcv_pulse_in = 14'h0000;
    prev = 14'h0000;
    for (int i = 0; i < 14; i++) cnt[i] = 0;
    sys_rst_in = 1'b1;
    repeat (16) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(8'he5, 8'h00);
    rd(8'he6, 8'h00);
    rd(8'he8, 8'h00);
    wr(8'he5, 8'h71);
    rd(8'he5, 8'h71);
    wr(8'he6, 8'he0);
    rd(8'he6, 8'he0);
    rd(8'he7, 8'h00);
    wr(8'he6, 8'h00);
    // random traffic on all channels, monitor shows activity one cycle late
    repeat (200) begin
      @(posedge sys_clk_in);
      cur = lcvc_chvec_t'($random(seed));
      lcv_pulse_in <= cur;
      #1;
      cmp_vec("monitor", prev, monitor_status_out);
      cmp_vec("overflow", 14'h0000, overflow_out);
      for (int i = 0; i < 14; i++) if (cur[i]) cnt[i]++;
      prev = cur;
    end
    @(posedge sys_clk_in);
    lcv_pulse_in <= 14'h0000;
    ctl(8'h08, 2);
    for (int c = 0; c < 16; c++) rd_chan(c[3:0], 1'b1, (c >= 1 && c <= 14) ? cnt[c-1][15:0] : 16'h0000);
    rd_chan(4'h1, 1'b0, 16'h0000);
    pulse(14'h3fff, 3);
    wr(8'he5, 8'h46);
    ctl(8'h02, 2);
    rd_chan(4'h6, 1'b1, cnt[5][15:0]);
    rd_chan(4'h5, 1'b1, cnt[4][15:0] - 16'h0003);
    wr(8'he5, 8'h46);
    ctl(8'h01, 100);
    ctl(8'h08, 2);
    rd_chan(4'h6, 1'b1, 16'h0000);
    rd_chan(4'h5, 1'b1, cnt[4][15:0]);
    ctl(8'h10, 100);
    ctl(8'h08, 2);
    rd_chan(4'h5, 1'b1, 16'h0000);
    // saturation: one short of full scale, then past it
    mon = 1'b1;
    wr(8'he5, 8'hc1);
    pulse(14'h3fff, 65534);
    #1;
    // last pulse was just registered, so a pulse-fed monitor would show it here
    cmp_vec("monitor", 14'h0000, monitor_status_out);
    repeat (2) @(posedge sys_clk_in);
    #1;
    cmp_vec("overflow", 14'h0000, overflow_out);
    ctl(8'h08, 2);
    rd_chan(4'h1, 1'b1, 16'hfffe);
    pulse(14'h3fff, 5);
    repeat (2) @(posedge sys_clk_in);
    #1;
    cmp_vec("overflow", 14'h3fff, overflow_out);
    cmp_vec("monitor", 14'h3fff, monitor_status_out);
    ctl(8'h08, 2);
    rd_chan(4'he, 1'b1, 16'hffff);
    wr(8'he5, 8'hce);
    ctl(8'h01, 100);
    #1;
    cmp_vec("overflow", 14'h1fff, overflow_out);
    repeat (3) @(posedge sys_clk_in);
    tally_and_finish();
  end

endmodule : lcvc_bank_tb
